// File: src/sts_pkg.sv
/*
 * Constants shared by the secure timestamp sequence logic: register
 * offsets, field positions, reset values, packet configurations, counts.
 * Assumes a single 25 MHz system clock and a plain register port.
 */
`default_nettype none
package sts_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_SYS_CFG    = 6'h00;
    localparam logic [5:0] OFF_STS_CONFIG_REG    = 6'h01;
    localparam logic [5:0] OFF_KEY0       = 6'h04;
    localparam logic [5:0] OFF_NONCE0     = 6'h08;
    localparam logic [5:0] OFF_STATUS     = 6'h0c;
    localparam logic [5:0] OFF_RX_STAMP   = 6'h0d;
    localparam logic [5:0] OFF_ACC_BASE   = 6'h20;
    localparam int SPC_POS     = 0;
    localparam int SDC_POS     = 2;
    localparam int LEA_EN_POS  = 3;
    localparam int LEN_POS     = 0;
    localparam int LEN_W       = 8;
    localparam int QUAL_W      = 12;
    localparam int DONE_POS    = 31;
    localparam int TOAST_POS   = 30;
    localparam logic [7:0]  LEN_RESET = 8'h07;
    localparam logic [31:0] SYS_CFG_RESET = 32'h0000_0008;
    localparam int UNIT_STEP   = 8;
    localparam int UNIT_CHIPS  = 512;
    localparam int LEN_MIN     = 32;
    localparam int LEN_MAX     = 2048;
    localparam int PULSE_CHIPS = 8;
    localparam int PULSES_PER_CTR = 128;
    localparam int GAP_CHIPS   = 512;
    localparam int QUAL_PCT    = 60;
    localparam int ANALYSE_CYCLES = 16;
    localparam int ACC_DEPTH   = 16;
    typedef enum logic [1:0] {
        SPC_OFF = 2'd0, SPC_AFTER_SFD = 2'd1, SPC_AT_END = 2'd2, SPC_NO_DATA = 2'd3
    } spc_t;
endpackage
`default_nettype wire

// File: src/sts_prng.sv
/*
 * Pulse generator for the timestamp sequence: a keyed counter-mode
 * scrambler or a fixed deterministic code. Assumes the caller pulses
 * step_i once per pulse and loads the nonce only while idle.
 */
`default_nettype none
module sts_prng (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic [127:0] key_i,
    input  wire logic [127:0] nonce_i,
    input  wire logic         load_i,
    input  wire logic         step_i,
    input  wire logic         sdc_i,
    output logic              pulse_o,
    output logic [127:0]      counter_o
);
    import sts_pkg::*;
    typedef struct packed {
        logic [127:0] ctr;
        logic [6:0]   idx;
        logic [31:0]  lfsr;
        logic         pol;
    } st_t;
    st_t st;
    st_t next_st;
    logic [31:0] mix;

    // Keyed mix stands in for the cipher core, which sits outside this block
    always_comb begin
        next_st = st;
        mix = st.ctr[31:0] ^ key_i[31:0] ^ key_i[127:96] ^ {25'h0, st.idx};
        if (load_i) begin
            next_st.ctr = nonce_i;
            next_st.idx = 7'h0;
        end else if (step_i) begin
            next_st.idx = st.idx + 7'h1;
            next_st.lfsr = {st.lfsr[30:0], ^(st.lfsr & 32'h8020_0003)};
            next_st.pol = sdc_i ? st.lfsr[0] ^ st.idx[0] : ^mix; // R18 R7
            if (st.idx == 7'h7f) begin
                next_st.ctr = st.ctr + 128'h1; // R7
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{ctr: 128'h0, idx: 7'h0, lfsr: 32'h0000_0001, pol: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pulse_o = st.pol;
    assign counter_o = st.ctr;
endmodule
`default_nettype wire

// File: src/sts_accum.sv
/*
 * Impulse-response accumulator: one bank for the preamble, one for the
 * sequence. Assumes a single writer port and a shared read port.
 */
`default_nettype none
module sts_accum #(
    parameter int DEPTH = sts_pkg::ACC_DEPTH
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     clr_i,
    input  wire logic                     wr_i,
    input  wire logic                     bank_i,
    input  wire logic [$clog2(DEPTH)-1:0] tap_i,
    input  wire logic signed [15:0]       sample_i,
    input  wire logic                     rd_bank_i,
    input  wire logic [$clog2(DEPTH)-1:0] rd_tap_i,
    output logic [31:0]                   rd_data_o
);
    import sts_pkg::*;
    logic signed [31:0] mem [2][DEPTH];

    // R12
    generate
        for (genvar b = 0; b < 2; b++) begin : g_bank
            always_ff @(posedge sys_clk_i) begin
                if (clr_i) begin
                    for (int t = 0; t < DEPTH; t++) begin
                        mem[b][t] <= 32'sh0;
                    end
                end else if (wr_i && bank_i == 1'(b)) begin
                    mem[b][tap_i] <= mem[b][tap_i] + 32'(sample_i);
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 32'h0;
        end else begin
            rd_data_o <= mem[rd_bank_i][rd_tap_i];
        end
    end
endmodule
`default_nettype wire

// File: src/sts_ctrl.sv
/*
 * Secure timestamp sequence control: places the sequence in the packet,
 * runs its length and gaps, drives the pulse generator, collects two
 * accumulations and sequences the leading-edge analyser.
 * Assumes a plain register port and a radio front end on the same clock.
 */
//
// Behaviour
// R1: Mode 3 ends packet after sequence
// R2: Packet configuration from system config field
// R3: Length field in steps of eight units
// R4: Length bounded between 32 and 2048 units
// R5: Pulses every eight chips, 64 MHz
// R6: Seed from key and nonce registers
// R7: Random polarity, counter step per 128
// R8: Mandated sequence advances counter by 32
// R9: Both ends share length, key, nonce
// R10: Host rewrites nonce when alignment lost
// R11: Host touches nonce only while idle
// R12: Separate preamble and sequence accumulations
// R13: Analyser does preamble then sequence, stamps
// R14: Host checks quality status first
// R15: Host reads accumulator after done flag
// R16: Quality below 60 percent is unreliable
// R17: Field 15 means 128, threshold 77
// R18: Deterministic code replaces keyed sequence
// R19: Mode 1 sequence before header, payload
// R20: Mode 2 sequence after nonzero payload
// R21: Silent 512-chip gaps around sequence
// R22: Done flag after both analyses update
`default_nettype none
module sts_ctrl (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic [sts_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [31:0]                 wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic [31:0]                      rdata_o,
    input  wire logic                        chip_tick_i,
    input  wire logic                        sfd_done_i,
    input  wire logic                        payload_done_i,
    input  wire logic [9:0]                  payload_len_i,
    input  wire logic                        rx_mode_i,
    input  wire logic                        pkt_start_i,
    input  wire logic signed [15:0]          rx_sample_i,
    input  wire logic                        rx_valid_i,
    input  wire logic [39:0]                 coarse_stamp_i,
    output logic                             sts_active_o,
    output logic                             pulse_en_o,
    output logic                             pulse_pol_o,
    output logic                             send_header_o,
    output logic                             pkt_end_o,
    output logic                             len_error_o
);
    import sts_pkg::*;

    typedef enum {
        S_IDLE, S_PRE, S_WAIT, S_GAP1, S_ACTIVE, S_GAP2, S_DATA, S_LEA_PRE, S_LEA_STS
    } state_t;

    typedef struct packed {
        state_t       state;
        logic [31:0]  sys_cfg;
        logic [7:0]   len_field;
        logic [127:0] key;
        logic [127:0] nonce;
        logic [11:0]  chip_cnt;
        logic [11:0]  unit_cnt;
        logic [11:0]  qual;
        logic         toast_bad;
        logic         done;
        logic [39:0]  stamp;
        logic         pre_peak_ok;
        logic [3:0]   tap;
        logic [4:0]   lea_cnt;
        logic         ended;
        logic         len_err;
        logic [31:0]  rdata;
        logic         rd_acc;
    } st_t;

    st_t  st;
    st_t  next_st;
    spc_t spc;
    logic sdc_en;
    logic lea_en;
    logic [11:0] units;
    logic [11:0] qual_min;
    logic        pulse_step;
    logic        prng_load;
    logic        prng_pol;
    logic [127:0] prng_ctr;
    logic [31:0] acc_rdata;
    logic        acc_bank;
    logic        acc_wr;
    logic        chip_last;
    logic        unit_last;

    assign spc = spc_t'(st.sys_cfg[SPC_POS +: 2]); // R2
    assign sdc_en = st.sys_cfg[SDC_POS];
    assign lea_en = st.sys_cfg[LEA_EN_POS];
    // Field n selects 8*(n+1) units, floored at the shortest supported
    always_comb begin
        units = 12'((32'(st.len_field) + 32'd1) * UNIT_STEP); // R3 R17
        if (units < 12'(LEN_MIN)) begin
            units = 12'(LEN_MIN); // R4
        end
    end
    // Field width caps at 2048 units, so the 8-bit LEN_W already reaches LEN_MAX
    assign qual_min = 12'((32'(units) * QUAL_PCT + 99) / 100); // R16 R17
    assign chip_last = st.chip_cnt == 12'(UNIT_CHIPS - 1);
    assign unit_last = st.unit_cnt == units - 12'h1;
    assign pulse_step = st.state == S_ACTIVE && chip_tick_i
                        && st.chip_cnt[2:0] == 3'(PULSE_CHIPS - 1); // R5
    assign prng_load = wr_i && addr_i >= OFF_NONCE0 && addr_i < OFF_NONCE0 + 6'h4;
    assign acc_bank = st.state == S_ACTIVE;
    assign acc_wr = rx_mode_i && rx_valid_i && (st.state == S_PRE || acc_bank); // R12

    sts_prng u_prng (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .key_i     (st.key),
        .nonce_i   (next_st.nonce),
        .load_i    (prng_load || st.state == S_IDLE && pkt_start_i),
        .step_i    (pulse_step),
        .sdc_i     (sdc_en),
        .pulse_o   (prng_pol),
        .counter_o (prng_ctr)
    );

    sts_accum #(.DEPTH(ACC_DEPTH)) u_acc (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clr_i     (st.state == S_IDLE && pkt_start_i),
        .wr_i      (acc_wr),
        .bank_i    (acc_bank),
        .tap_i     (st.chip_cnt[3:0]),
        .sample_i  (rx_sample_i),
        .rd_bank_i (addr_i[4]),
        .rd_tap_i  (addr_i[3:0]),
        .rd_data_o (acc_rdata)
    );

    always_comb begin
        next_st = st;
        next_st.rd_acc = rd_i && addr_i >= OFF_ACC_BASE;
        // Register writes
        if (wr_i) begin
            case (addr_i)
                OFF_SYS_CFG: next_st.sys_cfg = wdata_i;
                OFF_STS_CONFIG_REG: next_st.len_field = wdata_i[LEN_POS +: LEN_W];
                OFF_STATUS: next_st.done = st.done & ~wdata_i[DONE_POS];
                default: begin
                    if (addr_i >= OFF_KEY0 && addr_i < OFF_KEY0 + 6'h4) begin
                        next_st.key[32*addr_i[1:0] +: 32] = wdata_i; // R6
                    end
                    if (prng_load) begin
                        next_st.nonce[32*addr_i[1:0] +: 32] = wdata_i; // R6 R10
                    end
                end
            endcase
        end
        // Live counter shows through the nonce register once a packet ran
        if (st.state == S_IDLE && !prng_load) begin
            next_st.nonce = prng_ctr; // R8
        end
        if (chip_tick_i) begin
            next_st.chip_cnt = chip_last ? 12'h0 : st.chip_cnt + 12'h1;
        end
        case (st.state)
            S_IDLE: begin
                if (pkt_start_i && spc != SPC_OFF) begin
                    next_st.state = S_PRE;
                    next_st.ended = 1'b0;
                    next_st.len_err = 1'b0;
                    next_st.qual = 12'h0;
                    next_st.chip_cnt = 12'h0;
                end
            end
            S_PRE: begin
                if (sfd_done_i) begin
                    next_st.chip_cnt = 12'h0;
                    next_st.stamp = coarse_stamp_i;
                    if (spc == SPC_AT_END) begin
                        next_st.state = S_WAIT; // R20
                        next_st.len_err = payload_len_i == 10'h0; // R20
                    end else begin
                        next_st.state = S_GAP1; // R1 R19
                    end
                end
            end
            S_WAIT: begin
                if (payload_done_i) begin
                    next_st.state = S_GAP1;
                    next_st.chip_cnt = 12'h0;
                end
            end
            S_GAP1: begin
                if (chip_tick_i && chip_last) begin
                    next_st.state = S_ACTIVE; // R21
                    next_st.unit_cnt = 12'h0;
                end
            end
            S_ACTIVE: begin
                // Graded once per unit by its closing sample, so the count
                // stays in units and compares straight against the length
                if (chip_tick_i && chip_last && acc_wr && rx_sample_i > 16'sh0) begin
                    next_st.qual = st.qual + 12'h1; // R16
                end
                if (chip_tick_i && chip_last) begin
                    next_st.unit_cnt = st.unit_cnt + 12'h1;
                    if (unit_last) begin
                        next_st.state = S_GAP2; // R4
                    end
                end
            end
            S_GAP2: begin
                if (chip_tick_i && chip_last) begin // R21
                    next_st.state = spc == SPC_AFTER_SFD ? S_DATA : S_LEA_PRE; // R19
                    next_st.ended = spc == SPC_NO_DATA; // R1
                    next_st.lea_cnt = 5'h0;
                end
            end
            S_DATA: begin
                if (payload_done_i) begin
                    next_st.state = S_LEA_PRE;
                    next_st.lea_cnt = 5'h0;
                end
            end
            S_LEA_PRE: begin
                if (!rx_mode_i || !lea_en) begin
                    next_st.state = S_IDLE;
                end else begin
                    next_st.lea_cnt = st.lea_cnt + 5'h1; // R13
                    if (st.lea_cnt == 5'(ANALYSE_CYCLES - 1)) begin
                        next_st.pre_peak_ok = acc_rdata != 32'h0;
                        next_st.lea_cnt = 5'h0;
                        next_st.state = S_LEA_STS;
                    end
                end
            end
            S_LEA_STS: begin
                next_st.lea_cnt = st.lea_cnt + 5'h1;
                if (st.lea_cnt == 5'(ANALYSE_CYCLES - 1)) begin
                    next_st.stamp = st.stamp + {36'h0, st.tap}; // R13
                    next_st.toast_bad = st.qual < qual_min || st.len_err; // R16
                    next_st.done = 1'b1; // R22
                    next_st.state = S_IDLE;
                end
            end
            default: next_st.state = S_IDLE;
        endcase
        // Read data, one cycle after the strobe
        next_st.rdata = 32'h0;
        if (rd_i) begin
            case (addr_i)
                OFF_SYS_CFG: next_st.rdata = st.sys_cfg;
                OFF_STS_CONFIG_REG: next_st.rdata = {24'h0, st.len_field};
                OFF_STATUS: next_st.rdata = {st.done, st.toast_bad, 18'h0, st.qual}; // R14
                OFF_RX_STAMP: next_st.rdata = st.stamp[31:0];
                OFF_RX_STAMP + 6'h1: next_st.rdata = {24'h0, st.stamp[39:32]};
                default: begin
                    if (addr_i >= OFF_KEY0 && addr_i < OFF_KEY0 + 6'h4) begin
                        next_st.rdata = st.key[32*addr_i[1:0] +: 32];
                    end
                    if (addr_i >= OFF_NONCE0 && addr_i < OFF_NONCE0 + 6'h4) begin
                        next_st.rdata = st.nonce[32*addr_i[1:0] +: 32];
                    end
                end
            endcase
        end
        // Done set wins over a clear in the same cycle
        if (st.state == S_LEA_STS && st.lea_cnt == 5'(ANALYSE_CYCLES - 1)) begin
            next_st.done = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{state: S_IDLE, sys_cfg: SYS_CFG_RESET, len_field: LEN_RESET,
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rd_acc ? acc_rdata : st.rdata; // R15
    assign sts_active_o = st.state == S_ACTIVE;
    assign pulse_en_o = pulse_step;
    assign pulse_pol_o = prng_pol; // R7
    assign send_header_o = spc != SPC_NO_DATA; // R1
    assign pkt_end_o = st.ended;
    assign len_error_o = st.len_err;

    property p_gap_silent;
        @(posedge sys_clk_i) disable iff (rst_i)
        (st.state == S_GAP1 || st.state == S_GAP2) |-> !pulse_en_o;
    endproperty
    a_gap_silent: assert property (p_gap_silent) else $error("pulse in gap"); // R21

    property p_pulse_spacing;
        @(posedge sys_clk_i) disable iff (rst_i)
        pulse_en_o |=> !pulse_en_o;
    endproperty
    a_pulse_spacing: assert property (p_pulse_spacing) else $error("pulses too close"); // R5

    property p_mode3_end;
        @(posedge sys_clk_i) disable iff (rst_i)
        (st.state == S_GAP2 && chip_tick_i && chip_last && spc == SPC_NO_DATA)
            |=> pkt_end_o && st.state != S_DATA;
    endproperty
    a_mode3_end: assert property (p_mode3_end) else $error("mode 3 did not end"); // R1

    property p_len_floor;
        @(posedge sys_clk_i) disable iff (rst_i) units >= 12'(LEN_MIN);
    endproperty
    a_len_floor: assert property (p_len_floor) else $error("length below floor"); // R4

    property p_len15;
        @(posedge sys_clk_i) disable iff (rst_i)
        st.len_field == 8'd15 |-> units == 12'd128 && qual_min == 12'd77;
    endproperty
    a_len15: assert property (p_len15) else $error("length 15 mapping wrong"); // R17

    property p_lea_order;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(st.state == S_LEA_STS) |-> $past(st.state == S_LEA_PRE);
    endproperty
    a_lea_order: assert property (p_lea_order) else $error("analyser order wrong"); // R13

    property p_done_after;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(st.done) |-> $past(st.state == S_LEA_STS);
    endproperty
    a_done_after: assert property (p_done_after) else $error("done raised early"); // R22

    property p_ctr_step;
        @(posedge sys_clk_i) disable iff (rst_i)
        pulse_step && !prng_load && st.state != S_IDLE && u_prng.st.idx == 7'h7f
            |=> prng_ctr == $past(prng_ctr) + 128'h1;
    endproperty
    a_ctr_step: assert property (p_ctr_step) else $error("counter did not step"); // R7 R8
endmodule
`default_nettype wire

// File: tb/sts_air_model.sv
/*
 * Behavioural remote transceiver and radio front end: chip ticks,
 * packet start, frame delimiter and received samples.
 * Assumes the bench holds run_i high for a whole frame.
 */
`default_nettype none
module sts_air_model (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          run_i,
    input  wire logic          rx_mode_i,
    output logic               chip_tick_o,
    output logic               pkt_start_o,
    output logic               sfd_done_o,
    output logic signed [15:0] sample_o,
    output logic               valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] lfsr;
    int          ticks;
    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr <= 32'hb312;
            ticks <= 0;
            chip_tick_o <= 1'b0;
            pkt_start_o <= 1'b0;
            sfd_done_o <= 1'b0;
            sample_o <= 16'h0000;
            valid_o <= 1'b0;
        end else begin
            lfsr <= next_lfsr(lfsr);
            // Air clock stands still between frames
            chip_tick_o <= run_i;
            pkt_start_o <= run_i && ticks == 0;
            sfd_done_o <= run_i && ticks == 64;
            ticks <= run_i ? ticks + 1 : 0;
            valid_o <= run_i && rx_mode_i;
            // Changes every cycle, so a stale sample never looks valid
            sample_o <= lfsr[15:0];
        end
    end
endmodule
`default_nettype wire

// File: tb/sts_sequence_and_toa_control_test.sv
/*
 * Self-checking bench for the sequence control block.
 * Assumes the air model and a 25 MHz clock.
 */
`default_nettype none
module sts_sequence_and_toa_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sts_pkg::*;
    logic               sys_clk_i, rst_i, wr_i, rd_i, rx_mode, run;
    logic [ADDR_W-1:0]  addr_i;
    logic [31:0]        wdata_i, rdata_o, v;
    logic [9:0]         pay_len;
    logic               tick, pstart, sfd, valid, active, pen, ppol;
    logic               hdr, pend, lerr;
    logic signed [15:0] smp;
    int                 failures, compares, act, pulses, npos, nneg, qpos, gap, n, u, sacc;
    sts_air_model u_air (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run),
        .rx_mode_i(rx_mode), .chip_tick_o(tick), .pkt_start_o(pstart),
        .sfd_done_o(sfd), .sample_o(smp), .valid_o(valid));
    sts_ctrl u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .chip_tick_i(tick), .sfd_done_i(sfd), .payload_done_i(1'b0),
        .payload_len_i(pay_len), .rx_mode_i(rx_mode), .pkt_start_i(pstart),
        .rx_sample_i(smp), .rx_valid_i(valid), .coarse_stamp_i(40'h12_3456_7890),
        .sts_active_o(active), .pulse_en_o(pen), .pulse_pol_o(ppol),
        .send_header_o(hdr), .pkt_end_o(pend), .len_error_o(lerr));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        act += int'(active === 1'b1);
        pulses += int'(pen === 1'b1);
        npos += int'(pen === 1'b1 && ppol === 1'b1);
        nneg += int'(pen === 1'b1 && ppol === 1'b0);
        // Unit quality: the sample that closes each 512-chip unit
        qpos += int'(active === 1'b1 && valid === 1'b1 && smp > 0 && act % UNIT_CHIPS == 0);
        if (active === 1'b1 && valid === 1'b1 && act % ACC_DEPTH == 1)
            sacc += smp;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(posedge sys_clk_i);
        d = rdata_o;
    endtask
    // Model: units from the length field, floored and capped
    function automatic int units_of(input int f);
        int x;
        x = UNIT_STEP * (f + 1);
        return x < LEN_MIN ? LEN_MIN : (x > LEN_MAX ? LEN_MAX : x);
    endfunction
    task automatic run_packet(input logic rx);
        rx_mode <= rx;
        run <= 1'b1;
        act = 0;
        pulses = 0;
        npos = 0;
        nneg = 0;
        qpos = 0;
        sacc = 0;
        gap = 0;
        n = 0;
        while (sfd !== 1'b1 && n < 1000) begin
            @(posedge sys_clk_i);
            n++;
        end
        while (active !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_i);
            gap++;
            n++;
        end
        n = 0;
        while (pend !== 1'b1 && n < 70000) begin
            @(posedge sys_clk_i);
            n++;
        end
        check(pend, 1'b1, "packet end after sequence");
        run <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic finish_test();
        $display("Counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #(40 * 80000);
        failures++;
        finish_test();
    end
    initial begin
        failures = 0;
        compares = 0;
        {wr_i, rd_i, rx_mode, run} = 4'h0;
        addr_i = '0;
        wdata_i = 32'h0;
        pay_len = 10'h000;
        rst_i = 1'b1;
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        reg_rd(OFF_SYS_CFG, v);
        check(v, SYS_CFG_RESET, "sys cfg reset");
        reg_rd(OFF_STS_CONFIG_REG, v);
        check(v[LEN_W-1:0], LEN_RESET, "length reset");
        check(hdr, 1'b1, "header at reset");
        reg_rd(6'h10, v);
        check(v, 32'h0, "unmapped read");
        for (int c = 0; c < 4; c++) begin
            reg_wr(OFF_SYS_CFG, 32'(c));
            @(posedge sys_clk_i);
            check(hdr, 1'(c != 3), "header per config");
            check(lerr, 1'b0, "no error without packet");
        end
        pay_len <= 10'd5;
        reg_wr(OFF_SYS_CFG, 32'h2);
        @(posedge sys_clk_i);
        check(lerr, 1'b0, "payload present");
        $display("Test configuration done");
        // Same key and nonce as the far end would use, written while idle
        for (int w = 0; w < 4; w++) begin
            reg_wr(6'(OFF_KEY0 + w), 32'h1111_1111 * (w + 1));
            reg_wr(6'(OFF_NONCE0 + w), w == 0 ? 32'h100 : 32'h0);
        end
        reg_rd(OFF_NONCE0, v);
        check(v, 32'h100, "nonce load");
        reg_wr(OFF_STS_CONFIG_REG, 32'h7);
        reg_wr(OFF_SYS_CFG, 32'h3);
        run_packet(1'b0);
        u = units_of(7);
        check(act, u * UNIT_CHIPS, "active length");
        check(pulses, u * UNIT_CHIPS / PULSE_CHIPS, "pulse count");
        check(npos > 0 && nneg > 0, 1, "both polarities");
        check(gap >= GAP_CHIPS && gap <= GAP_CHIPS + 2, 1, "leading gap");
        reg_rd(OFF_NONCE0, v);
        check(v, 32'h100 + u * UNIT_CHIPS / PULSE_CHIPS / PULSES_PER_CTR, "ctr");
        $display("Test transmit done");
        reg_wr(OFF_NONCE0, 32'h0);
        reg_wr(OFF_STS_CONFIG_REG, 32'h0);
        reg_wr(OFF_SYS_CFG, 32'hf);
        run_packet(1'b1);
        u = units_of(0);
        check(act, u * UNIT_CHIPS, "minimum length");
        n = 0;
        v = 32'h0;
        while (v[DONE_POS] !== 1'b1 && n < 200) begin
            reg_rd(OFF_STATUS, v);
            n++;
        end
        check(v[DONE_POS], 1'b1, "analyser done");
        check(v[QUAL_W-1:0], qpos, "quality count");
        check(v[TOAST_POS], 1'(qpos < (QUAL_PCT * u + 99) / 100), "bad");
        reg_rd(6'(OFF_ACC_BASE + 16), v);
        check(v, sacc, "sequence accumulation tap 0");
        reg_rd(OFF_RX_STAMP, v);
        check(v, 32'h3456_7890, "rx stamp");
        reg_wr(OFF_STATUS, 32'h8000_0000);
        reg_rd(OFF_STATUS, v);
        check(v[DONE_POS], 1'b0, "done cleared");
        $display("Test receive done");
        reg_wr(OFF_STS_CONFIG_REG, 32'hf);
        reg_rd(OFF_STS_CONFIG_REG, v);
        check(v, 32'hf, "length field 15");
        pay_len <= 10'd0;
        reg_wr(OFF_SYS_CFG, 32'h2);
        run <= 1'b1;
        n = 0;
        while (sfd !== 1'b1 && n < 1000) begin
            @(posedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
        check(lerr, 1'b1, "zero payload error");
        // Reset in mid-packet; the design is parked waiting for a payload
        rst_i <= 1'b1;
        run <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        check(lerr, 1'b0, "error cleared by reset");
        reg_rd(OFF_SYS_CFG, v);
        check(v, SYS_CFG_RESET, "sys cfg after reset");
        $display("Test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
